// File: hdl/hst_pkg.sv
// Shared constants and carrier types for the fast amplifier configuration bank
package hst_pkg;

  // Bus geometry
  localparam int HST_ADDR_W = 16;
  localparam int HST_DATA_W = 32;

  // Byte addresses
  localparam logic [15:0] HST_ADDR_FRONT_END_CONTROL = 16'h2000;
  localparam logic [15:0] HST_ADDR_FAST_DAC_CONTROL = 16'h2010;
  localparam logic [15:0] HST_ADDR_FAST_GAIN_RES_CFG = 16'h20f0;
  localparam logic [15:0] HST_ADDR_ELECTRODE_RES_CFG = 16'h20f8;
  localparam logic [15:0] HST_ADDR_TIA_CONFIG = 16'h20fc;
  localparam logic [15:0] HST_ADDR_ADC_INPUT_SELECT = 16'h21a8;
  localparam logic [15:0] HST_ADDR_CALIBRATION_LOCK = 16'h2230;
  localparam logic [15:0] HST_ADDR_OFFSET_ATTEN_ON = 16'h22b8;
  localparam logic [15:0] HST_ADDR_OFFSET_ATTEN_OFF = 16'h22bc;

  // Reset values
  localparam logic [31:0] HST_RST_FRONT_END_CONTROL = 32'h0000_0000;
  localparam logic [31:0] HST_RST_FAST_DAC_CONTROL = 32'h0000_0000;
  localparam logic [3:0] HST_RST_FAST_GAIN_RES = 4'hf;
  localparam logic [7:0] HST_RST_ELECTRODE_RES = 8'hff;
  localparam logic [3:0] HST_RST_TIA_CONFIG = 4'h0;
  localparam logic [5:0] HST_RST_ADC_INPUT_SELECT = 6'h00;
  localparam logic [31:0] HST_RST_CALIBRATION_LOCK = 32'hde87_a5a0;
  localparam logic [11:0] HST_RST_OFFSET = 12'h000;

  // Lock key
  localparam logic [31:0] HST_LOCK_KEY = 32'hde87_a5af;

  // Field positions
  localparam int HST_BIT_TIA_ENABLE = 11;
  localparam int HST_BIT_DAC_ATTEN = 12;
  localparam int HST_BIT_DAC_GAIN_SEL = 0;
  localparam int HST_OFFSET_W = 12;
  localparam int HST_TIA_CM_BIT = 3;

  // Electrode resistor codes
  localparam logic [7:0] HST_RES_EXTERNAL = 8'h97;
  localparam logic [7:0] HST_RES_OPEN = 8'hff;
  localparam logic [3:0] HST_GAIN_EXTERNAL = 4'hf;
  localparam int HST_LOAD_SETTINGS = 5;

  // Converter mux code that picks the amplifier output
  localparam logic [5:0] HST_ADC_SEL_TIA = 6'h01;

  // Amplifier input choices
  typedef enum logic [2:0]
  {
    HST_IN_SINGLE_ENDED = 3'h0,
    HST_IN_ANALOG_0 = 3'h1,
    HST_IN_ANALOG_1 = 3'h2,
    HST_IN_ANALOG_2 = 3'h3,
    HST_IN_ANALOG_3 = 3'h4,
    HST_IN_ELECTRODE = 3'h5
  } hst_input_t;

  // Bus responses
  localparam logic [1:0] HST_RESP_OKAY = 2'b00;
  localparam logic [1:0] HST_RESP_DECERR = 2'b11;

  typedef struct packed
  {
    logic cm_from_zero_dac;
    logic [2:0] input_sel;
  } hst_tia_cfg_t;

  typedef struct packed
  {
    logic [5:0] input_onehot;
    logic [4:0] load_onehot;
    logic load_open;
    logic electrode_gain_en;
    logic electrode_shorted;
    logic external_gain;
    logic internal_gain_en;
  } hst_switch_t;

endpackage

// File: hdl/hst_regs.sv
// Register bank and AXI4-Lite slave for fast DAC offset and amplifier controls
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ns
// What this block does
// - Attenuator-on offset register: 12-bit field, upper bits read zero, resets to zero.
// - Attenuator-off offset register with identical layout and zero reset.
// - Offset registers take writes only while the lock holds the unlock key.
// - Offset codes are two's complement half-LSB steps from -half to +half scale.
// - Code one is +half LSB, all ones -half LSB, zero no correction.
// - Attenuator bit set picks attenuator-on offset, clear picks attenuator-off offset.
// - Amplifier is off after reset and powered only while control bit 11 is one.
// - Software picks amplifier input: single ended, four analog pins, or electrode.
// - Software picks common mode from bias reference or zero-output DAC.
// - Electrode load resistor offers 0, 10, 30, 50 and 100 ohm settings.
// - Electrode code 0x97 shorts electrode load and gain resistors.
// - Amplifier output is one selectable channel of the converter input mux.
module hst_regs
(
  // Clock and reset
  input logic aclk,
  input logic aresetn,
  // AXI4-Lite write address
  input logic [hst_pkg::HST_ADDR_W-1:0] s_axi_awaddr,
  input logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input logic [hst_pkg::HST_DATA_W-1:0] s_axi_wdata,
  input logic [3:0] s_axi_wstrb,
  input logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input logic s_axi_bready,
  // AXI4-Lite read address
  input logic [hst_pkg::HST_ADDR_W-1:0] s_axi_araddr,
  input logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [hst_pkg::HST_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input logic s_axi_rready,
  // DAC offset path
  output logic signed [hst_pkg::HST_OFFSET_W-1:0] dac_offset_half_lsb,
  output logic dac_atten_en,
  output logic calibration_unlocked,
  // Amplifier controls
  output logic tia_power_on,
  output logic tia_cm_from_zero_dac,
  output hst_pkg::hst_switch_t tia_switches,
  output logic adc_tia_selected
);
  import hst_pkg::*;

  // Byte-lane merge of a bus write into a stored word
  function automatic logic [31:0] merge_strb(input logic [31:0] old_val,
                                             input logic [31:0] new_val,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        res[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic is_mapped(input logic [15:0] addr);
    logic hit;
    hit = 1'b0;
    unique case (addr)
      HST_ADDR_FRONT_END_CONTROL, HST_ADDR_FAST_DAC_CONTROL, HST_ADDR_FAST_GAIN_RES_CFG,
      HST_ADDR_ELECTRODE_RES_CFG, HST_ADDR_TIA_CONFIG, HST_ADDR_ADC_INPUT_SELECT,
      HST_ADDR_CALIBRATION_LOCK, HST_ADDR_OFFSET_ATTEN_ON, HST_ADDR_OFFSET_ATTEN_OFF:
        hit = 1'b1;
      default:
        hit = 1'b0;
    endcase
    return hit;
  endfunction

  // Register storage
  logic [31:0] front_end_control_reg;
  logic [31:0] fast_dac_control_reg;
  logic [3:0] fast_gain_resistor_config_reg;
  logic [7:0] electrode_resistor_config_reg;
  hst_tia_cfg_t tia_cfg_reg;
  logic [5:0] adc_input_select_reg;
  logic [31:0] calibration_lock_reg;
  logic [11:0] hs_dac_offset_atten_on_reg;
  logic [11:0] hs_dac_offset_atten_off_reg;
  logic [11:0] offset_active_reg;
  // Bus state
  logic aw_held_reg;
  logic [15:0] awaddr_reg;
  logic w_held_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic do_write;
  logic lock_open;
  logic [31:0] read_word;
  // Address and data may arrive in either order; each is held until both are present
  assign s_axi_awready = !aw_held_reg;
  assign s_axi_wready = !w_held_reg;
  assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign lock_open = (calibration_lock_reg == HST_LOCK_KEY);
  // ----------------------------------------------------------------
  // Write channel capture
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg <= 1'b0;
      awaddr_reg <= '0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held_reg <= 1'b1;
      awaddr_reg <= s_axi_awaddr;
    end
    else if (do_write)
    begin
      aw_held_reg <= 1'b0;
    end
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held_reg <= 1'b0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held_reg <= 1'b1;
      wdata_reg <= s_axi_wdata;
      wstrb_reg <= s_axi_wstrb;
    end
    else if (do_write)
    begin
      w_held_reg <= 1'b0;
    end
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_reg <= 1'b0;
      bresp_reg <= HST_RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid_reg <= 1'b1;
      // A locked write still answers OKAY; it is simply dropped
      bresp_reg <= is_mapped(awaddr_reg) ? HST_RESP_OKAY : HST_RESP_DECERR;
    end
    else if (s_axi_bready)
    begin
      bvalid_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Calibration lock and protected offsets
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      calibration_lock_reg <= HST_RST_CALIBRATION_LOCK;
    end
    else if (do_write && awaddr_reg == HST_ADDR_CALIBRATION_LOCK)
    begin
      calibration_lock_reg <= merge_strb(calibration_lock_reg, wdata_reg, wstrb_reg);
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      hs_dac_offset_atten_on_reg <= HST_RST_OFFSET;
      hs_dac_offset_atten_off_reg <= HST_RST_OFFSET;
    end
    else if (do_write && lock_open)
    begin
      // Locked writes fall through untouched
      if (awaddr_reg == HST_ADDR_OFFSET_ATTEN_ON)
      begin
        hs_dac_offset_atten_on_reg <= 12'(merge_strb({20'h0_0000, hs_dac_offset_atten_on_reg},
                                                     wdata_reg, wstrb_reg));
      end
      if (awaddr_reg == HST_ADDR_OFFSET_ATTEN_OFF)
      begin
        hs_dac_offset_atten_off_reg <= 12'(merge_strb({20'h0_0000, hs_dac_offset_atten_off_reg},
                                                      wdata_reg, wstrb_reg));
      end
    end
  end
  // Offset in use follows the attenuator bit one cycle later
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      offset_active_reg <= HST_RST_OFFSET;
    end
    else if (fast_dac_control_reg[HST_BIT_DAC_ATTEN])
    begin
      offset_active_reg <= hs_dac_offset_atten_on_reg;
    end
    else
    begin
      offset_active_reg <= hs_dac_offset_atten_off_reg;
    end
  end
  // Two's complement code passed as signed half-LSB count
  assign dac_offset_half_lsb = $signed(offset_active_reg);
  assign dac_atten_en = fast_dac_control_reg[HST_BIT_DAC_ATTEN];
  assign calibration_unlocked = lock_open;

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      front_end_control_reg <= HST_RST_FRONT_END_CONTROL;
      fast_dac_control_reg <= HST_RST_FAST_DAC_CONTROL;
    end
    else if (do_write)
    begin
      if (awaddr_reg == HST_ADDR_FRONT_END_CONTROL)
      begin
        front_end_control_reg <= merge_strb(front_end_control_reg, wdata_reg, wstrb_reg);
      end
      if (awaddr_reg == HST_ADDR_FAST_DAC_CONTROL)
      begin
        fast_dac_control_reg <= merge_strb(fast_dac_control_reg, wdata_reg, wstrb_reg);
      end
    end
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fast_gain_resistor_config_reg <= HST_RST_FAST_GAIN_RES;
      electrode_resistor_config_reg <= HST_RST_ELECTRODE_RES;
      tia_cfg_reg <= HST_RST_TIA_CONFIG;
      adc_input_select_reg <= HST_RST_ADC_INPUT_SELECT;
    end
    else if (do_write)
    begin
      if (awaddr_reg == HST_ADDR_FAST_GAIN_RES_CFG && wstrb_reg[0])
      begin
        fast_gain_resistor_config_reg <= wdata_reg[3:0];
      end
      if (awaddr_reg == HST_ADDR_ELECTRODE_RES_CFG && wstrb_reg[0])
      begin
        electrode_resistor_config_reg <= wdata_reg[7:0];
      end
      if (awaddr_reg == HST_ADDR_TIA_CONFIG && wstrb_reg[0])
      begin
        tia_cfg_reg <= wdata_reg[3:0];
      end
      if (awaddr_reg == HST_ADDR_ADC_INPUT_SELECT && wstrb_reg[0])
      begin
        adc_input_select_reg <= wdata_reg[5:0];
      end
    end
  end
  assign tia_power_on = front_end_control_reg[HST_BIT_TIA_ENABLE];
  assign tia_cm_from_zero_dac = tia_cfg_reg.cm_from_zero_dac;
  assign adc_tia_selected = tia_power_on && (adc_input_select_reg == HST_ADC_SEL_TIA);

  hst_res_decode u_res_decode
  (
    .tia_cfg(tia_cfg_reg),
    .electrode_res(electrode_resistor_config_reg),
    .gain_res(fast_gain_resistor_config_reg),
    .switches(tia_switches)
  );

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  always_comb
  begin
    read_word = 32'h0000_0000;
    unique case (s_axi_araddr)
      HST_ADDR_FRONT_END_CONTROL: read_word = front_end_control_reg;
      HST_ADDR_FAST_DAC_CONTROL: read_word = fast_dac_control_reg;
      HST_ADDR_FAST_GAIN_RES_CFG: read_word = {28'h000_0000, fast_gain_resistor_config_reg};
      HST_ADDR_ELECTRODE_RES_CFG: read_word = {24'h00_0000, electrode_resistor_config_reg};
      HST_ADDR_TIA_CONFIG: read_word = {28'h000_0000, tia_cfg_reg};
      HST_ADDR_ADC_INPUT_SELECT: read_word = {26'h000_0000, adc_input_select_reg};
      HST_ADDR_CALIBRATION_LOCK: read_word = calibration_lock_reg;
      HST_ADDR_OFFSET_ATTEN_ON: read_word = {20'h0_0000, hs_dac_offset_atten_on_reg};
      HST_ADDR_OFFSET_ATTEN_OFF: read_word = {20'h0_0000, hs_dac_offset_atten_off_reg};
      default: read_word = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= HST_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_reg <= 1'b1;
      rdata_reg <= read_word;
      rresp_reg <= is_mapped(s_axi_araddr) ? HST_RESP_OKAY : HST_RESP_DECERR;
    end
    else if (s_axi_rready)
    begin
      rvalid_reg <= 1'b0;
    end
  end

endmodule

// File: hdl/hst_res_decode.sv
// Switch decode for amplifier input, load and gain resistors
`timescale 1ns/1ns
module hst_res_decode
(
  // Configuration in
  input hst_pkg::hst_tia_cfg_t tia_cfg,
  input logic [7:0] electrode_res,
  input logic [3:0] gain_res,
  // Switch controls out
  output hst_pkg::hst_switch_t switches
);
  import hst_pkg::*;

  logic is_electrode;
  logic is_external;
  logic is_open;

  assign is_electrode = (tia_cfg.input_sel == HST_IN_ELECTRODE);
  assign is_external = (electrode_res == HST_RES_EXTERNAL);
  assign is_open = (electrode_res == HST_RES_OPEN);

  always_comb
  begin
    switches = '0;
    // Undefined input codes leave every input switch open
    if (tia_cfg.input_sel <= HST_IN_ELECTRODE)
    begin
      switches.input_onehot[tia_cfg.input_sel] = 1'b1;
    end
    // Load setting sits in the low three bits of the electrode code
    if (is_electrode && !is_external && !is_open &&
        electrode_res[2:0] < 3'(HST_LOAD_SETTINGS))
    begin
      switches.load_onehot[electrode_res[2:0]] = 1'b1;
    end
    switches.load_open = is_open || !is_electrode;
    // Small electrode gain values exist only on the electrode path
    switches.electrode_gain_en = is_electrode && !is_open && !is_external;
    switches.electrode_shorted = is_external;
    switches.external_gain = is_external && (gain_res == HST_GAIN_EXTERNAL);
    switches.internal_gain_en = (gain_res != HST_GAIN_EXTERNAL) && !switches.electrode_gain_en;
  end

endmodule

// File: sim/hs_dac_offset_cal_tia_config_tb.sv
// Self-checking bench for the fast amplifier configuration bank
`timescale 1ns/1ns
`define CHK(n, e, g) \
  begin \
    num_checks++; \
    if ((g) !== (e)) \
    begin \
      errors++; \
      $display("BAD %s exp %h got %h", n, e, g); \
    end \
  end
module hs_dac_offset_cal_tia_config_tb;
  import hst_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [15:0] s_axi_awaddr = 16'h0000;
  logic [15:0] s_axi_araddr = 16'h0000;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic signed [HST_OFFSET_W-1:0] dac_offset_half_lsb;
  logic dac_atten_en, calibration_unlocked, tia_power_on, tia_cm_from_zero_dac;
  logic adc_tia_selected;
  hst_switch_t tia_switches;
  int errors = 0;
  int num_checks = 0;
  int cycles = 0;
  int seed = 32'h992c55d3;
  logic [1:0] exp_b[$];
  logic [33:0] exp_r[$];
  logic [1:0] eb;
  logic [33:0] er;
  logic [31:0] rnd;
  logic [11:0] codes[5] = '{12'h7ff, 12'h001, 12'h000, 12'hfff, 12'h800};
  logic [7:0] loads[5] = '{8'h00, 8'h09, 8'h12, 8'h1b, 8'h34};

  always #25 aclk = ~aclk;

  hst_regs dut
  (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .dac_offset_half_lsb(dac_offset_half_lsb), .dac_atten_en(dac_atten_en),
    .calibration_unlocked(calibration_unlocked), .tia_power_on(tia_power_on),
    .tia_cm_from_zero_dac(tia_cm_from_zero_dac), .tia_switches(tia_switches),
    .adc_tia_selected(adc_tia_selected)
  );

  // ----------------------------------------
  // Reporting
  // ----------------------------------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic done(input string n);
    $display("test %s finished", n);
  endtask

  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      errors++;
      close_out();
    end
  end

  // Pre-edge values are seen here, before the design's flops update
  always @(posedge aclk)
  begin
    if (s_axi_bvalid && s_axi_bready)
    begin
      eb = exp_b.pop_front();
      `CHK("bresp", eb, s_axi_bresp)
    end
    if (s_axi_rvalid && s_axi_rready)
    begin
      er = exp_r.pop_front();
      `CHK("rresp", er[33:32], s_axi_rresp)
      `CHK("rdata", er[31:0], s_axi_rdata)
    end
  end

  // ----------------------------------------
  // Bus master
  // ----------------------------------------
  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s,
    input logic [1:0] r);
    @(posedge aclk);
    exp_b.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
        break;
    end
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    exp_r.push_back({r, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
        break;
    end
    s_axi_rready <= 1'b0;
  endtask

  // Offset output lags the registers by one edge
  task automatic idle();
    repeat (2) @(posedge aclk);
    #1;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial
  begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(HST_ADDR_OFFSET_ATTEN_ON, 32'h0, HST_RESP_OKAY);
    rd(HST_ADDR_OFFSET_ATTEN_OFF, 32'h0, HST_RESP_OKAY);
    rd(HST_ADDR_CALIBRATION_LOCK, HST_RST_CALIBRATION_LOCK, HST_RESP_OKAY);
    idle();
    `CHK("power", 1'b0, tia_power_on)
    `CHK("unlocked", 1'b0, calibration_unlocked)
    done("reset");
    wr(HST_ADDR_OFFSET_ATTEN_ON, 32'h0000_0123, 4'hf, HST_RESP_OKAY);
    rd(HST_ADDR_OFFSET_ATTEN_ON, 32'h0, HST_RESP_OKAY);
    // Low byte alone turns the reset word into the key
    wr(HST_ADDR_CALIBRATION_LOCK, 32'h0000_00af, 4'h1, HST_RESP_OKAY);
    idle();
    `CHK("unlocked", 1'b1, calibration_unlocked)
    rnd = $random(seed);
    wr(HST_ADDR_OFFSET_ATTEN_ON, rnd, 4'hf, HST_RESP_OKAY);
    rd(HST_ADDR_OFFSET_ATTEN_ON, {20'h0, rnd[11:0]}, HST_RESP_OKAY);
    rnd = $random(seed);
    wr(HST_ADDR_OFFSET_ATTEN_OFF, rnd, 4'hf, HST_RESP_OKAY);
    rd(HST_ADDR_OFFSET_ATTEN_OFF, {20'h0, rnd[11:0]}, HST_RESP_OKAY);
    done("lock");
    foreach (codes[i])
    begin
      wr(HST_ADDR_OFFSET_ATTEN_ON, {20'h0, codes[i]}, 4'hf, HST_RESP_OKAY);
      wr(HST_ADDR_OFFSET_ATTEN_OFF, {20'h0, ~codes[i]}, 4'hf, HST_RESP_OKAY);
      wr(HST_ADDR_FAST_DAC_CONTROL, 32'h0000_1000, 4'hf, HST_RESP_OKAY);
      idle();
      `CHK("offset atten on", codes[i], dac_offset_half_lsb)
      `CHK("atten", 1'b1, dac_atten_en)
      wr(HST_ADDR_FAST_DAC_CONTROL, 32'h0, 4'hf, HST_RESP_OKAY);
      idle();
      `CHK("offset atten off", ~codes[i], dac_offset_half_lsb)
      `CHK("atten", 1'b0, dac_atten_en)
    end
    done("offset codes");
    wr(HST_ADDR_CALIBRATION_LOCK, 32'h0, 4'hf, HST_RESP_OKAY);
    wr(HST_ADDR_OFFSET_ATTEN_OFF, 32'h0000_0555, 4'hf, HST_RESP_OKAY);
    rd(HST_ADDR_OFFSET_ATTEN_OFF, 32'h0000_07ff, HST_RESP_OKAY);
    idle();
    `CHK("offset relocked", 12'h7ff, dac_offset_half_lsb)
    wr(16'h2004, $random(seed), 4'hf, HST_RESP_DECERR);
    rd(16'h2004, 32'h0, HST_RESP_DECERR);
    done("relock and unmapped");
    wr(HST_ADDR_FRONT_END_CONTROL, 32'h0000_0800, 4'hf, HST_RESP_OKAY);
    wr(HST_ADDR_ADC_INPUT_SELECT, {26'h0, HST_ADC_SEL_TIA}, 4'hf, HST_RESP_OKAY);
    idle();
    `CHK("power", 1'b1, tia_power_on)
    `CHK("adc pick", 1'b1, adc_tia_selected)
    for (int i = 0; i < 6; i++)
    begin
      wr(HST_ADDR_TIA_CONFIG, {28'h0, i[0], i[2:0]}, 4'hf, HST_RESP_OKAY);
      idle();
      `CHK("input", 6'h01 << i, tia_switches.input_onehot)
      `CHK("common mode", i[0], tia_cm_from_zero_dac)
    end
    foreach (loads[i])
    begin
      wr(HST_ADDR_ELECTRODE_RES_CFG, {24'h0, loads[i]}, 4'hf, HST_RESP_OKAY);
      idle();
      `CHK("load", 5'h01 << i, tia_switches.load_onehot)
      `CHK("electrode gain", 1'b1, tia_switches.electrode_gain_en)
      `CHK("internal gain", 1'b0, tia_switches.internal_gain_en)
      `CHK("load open", 1'b0, tia_switches.load_open)
    end
    wr(HST_ADDR_ELECTRODE_RES_CFG, {24'h0, HST_RES_EXTERNAL}, 4'hf, HST_RESP_OKAY);
    wr(HST_ADDR_FAST_GAIN_RES_CFG, {28'h0, HST_GAIN_EXTERNAL}, 4'hf, HST_RESP_OKAY);
    // Far end of the resistor comes in on an analog pin
    wr(HST_ADDR_TIA_CONFIG, {28'h0, 1'b0, HST_IN_ANALOG_0}, 4'hf, HST_RESP_OKAY);
    idle();
    `CHK("far pin", 6'h02, tia_switches.input_onehot)
    `CHK("external", 1'b1, tia_switches.external_gain)
    `CHK("shorted", 1'b1, tia_switches.electrode_shorted)
    `CHK("load shorted", 5'h00, tia_switches.load_onehot)
    wr(HST_ADDR_FRONT_END_CONTROL, 32'h0, 4'hf, HST_RESP_OKAY);
    idle();
    `CHK("power", 1'b0, tia_power_on)
    `CHK("adc pick", 1'b0, adc_tia_selected)
    done("amplifier");
    close_out();
  end
endmodule

// File: sim/hst_regs_chk.sv
// Concurrent checks on the fast amplifier configuration bank ports
`timescale 1ns/1ns
module hst_regs_chk
(
  // Clock and reset
  input logic aclk,
  input logic aresetn,
  // Write response
  input logic s_axi_bvalid,
  // DAC offset path
  input logic signed [hst_pkg::HST_OFFSET_W-1:0] dac_offset_half_lsb,
  input logic dac_atten_en,
  input logic calibration_unlocked,
  // Amplifier controls
  input logic tia_power_on,
  input logic tia_cm_from_zero_dac,
  input hst_pkg::hst_switch_t tia_switches,
  input logic adc_tia_selected
);
  import hst_pkg::*;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Locked and no attenuator change: nothing may reach the offset output
  sequence s_quiet;
    !calibration_unlocked && $stable(dac_atten_en);
  endsequence

  sequence s_cfg_moved;
    $changed(tia_power_on) || $changed(dac_atten_en) || $changed(tia_cm_from_zero_dac)
      || $changed(calibration_unlocked);
  endsequence

  a_reset_state:
    assert property ($rose(aresetn) |-> !tia_power_on && !calibration_unlocked
      && dac_offset_half_lsb == '0)
    else $error("state after reset is wrong");
  a_locked_hold:
    assert property (s_quiet ##1 s_quiet |=> $stable(dac_offset_half_lsb))
    else $error("offset moved while locked");
  // Past reset guards against a one-edge reset landing mid-run
  a_cfg_by_write:
    assert property ($past(aresetn) ##0 s_cfg_moved |-> $rose(s_axi_bvalid))
    else $error("control changed without a write");
  a_tia_mux:
    assert property (adc_tia_selected |-> tia_power_on)
    else $error("converter picks a powered-down amplifier");
  a_short_ext:
    assert property (tia_switches.external_gain |-> tia_switches.electrode_shorted
      && !tia_switches.electrode_gain_en && tia_switches.load_onehot == 5'h00)
    else $error("external gain without shorted electrode resistors");
  a_load_sel:
    assert property (tia_switches.load_onehot != 5'h00 |-> $onehot(tia_switches.load_onehot)
      && tia_switches.input_onehot == 6'h20 && !tia_switches.load_open)
    else $error("load setting outside electrode input");
  a_input_sel:
    assert property ($onehot0(tia_switches.input_onehot))
    else $error("more than one amplifier input");
  a_gain_path:
    assert property (tia_switches.electrode_gain_en |-> tia_switches.input_onehot[5]
      && !tia_switches.internal_gain_en)
    else $error("two gain paths at once");
endmodule

bind hst_regs hst_regs_chk u_chk
(
  .aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid),
  .dac_offset_half_lsb(dac_offset_half_lsb), .dac_atten_en(dac_atten_en),
  .calibration_unlocked(calibration_unlocked), .tia_power_on(tia_power_on),
  .tia_cm_from_zero_dac(tia_cm_from_zero_dac), .tia_switches(tia_switches),
  .adc_tia_selected(adc_tia_selected)
);
